// ### common/line_status_pkg.sv
// register map and field layout of the line status and interrupt bank
package line_status_pkg;
  localparam logic [7:0] TERM_OFS       = 8'h32;
  localparam logic [7:0] LINE_IEN_OFS   = 8'h33;
  localparam logic [7:0] FAULT_IEN_OFS  = 8'h34;
  localparam logic [7:0] EDGE_SEL_OFS   = 8'h35;
  localparam logic [7:0] LIVE_OFS       = 8'h36;
  localparam logic [7:0] GAIN_OFS       = 8'h37;
  localparam logic [7:0] TX_SPREAD_OFS  = 8'h38;
  localparam logic [7:0] RX_SPREAD_OFS  = 8'h39;
  localparam logic [7:0] LINE_STAT_OFS  = 8'h3A;
  localparam logic [7:0] FAULT_STAT_OFS = 8'h3B;
  localparam logic [7:0] CNT_HI_OFS     = 8'h3C;
  localparam logic [7:0] CNT_LO_OFS     = 8'h3D;
  // bit positions and field masks
  localparam int DRIVER_BIT   = 2;
  localparam int ABSENT_BIT   = 0;
  localparam int TEMPLATE_BIT = 6;
  localparam int TX_FIFO_BIT  = 5;
  localparam int RX_FIFO_BIT  = 4;
  localparam int ZERO_BIT     = 2;
  localparam int BIPOLAR_BIT  = 1;
  localparam int WRAP_BIT     = 0;
  localparam int TX_TERM_LSB  = 3;
  localparam int RX_TERM_LSB  = 0;
  localparam logic [7:0] FAULT_MASK = 8'h77;
  localparam logic [7:0] LINE_MASK  = 8'h05;
  // reset values and termination select codes
  localparam logic [7:0] TERM_RST   = 8'h07;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [6:0] SPREAD_RST = 7'h00;
  localparam logic [2:0] TERM_75    = 3'h0;
  localparam logic [2:0] TERM_120   = 3'h1;
  localparam logic [2:0] TERM_100   = 3'h2;
  localparam logic [2:0] TERM_110   = 3'h3;
endpackage : line_status_pkg

// ### verilog/line_status_interrupt_bank.sv
// line status, jitter depth and sticky interrupt register bank
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module line_status_interrupt_bank
  import line_status_pkg::*;
#(
  parameter int SPREAD_W = 7
) (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [7:0]          addr_in,
  input  wire logic [7:0]          wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic [7:0]               rdata_out,
  input  wire logic                driver_fault_live_in,
  input  wire logic                signal_absent_live_in,
  input  wire logic [4:0]          rx_gain_code_in,
  input  wire logic [SPREAD_W-1:0] tx_pointer_spread_in,
  input  wire logic [SPREAD_W-1:0] rx_pointer_spread_in,
  input  wire logic                tx_spread_peak_mode_in,
  input  wire logic                rx_spread_peak_mode_in,
  input  wire logic                template_overflow_in,
  input  wire logic                tx_fifo_fault_in,
  input  wire logic                rx_fifo_fault_in,
  input  wire logic                zero_run_in,
  input  wire logic                bipolar_error_in,
  input  wire logic                counter_wrap_in,
  input  wire logic [15:0]         zero_count_in,
  output logic [2:0]               tx_term_sel_out,
  output logic [2:0]               rx_term_sel_out,
  output logic                     rx_term_bypass_out,
  output logic                     irq_n_out
);
  import line_status_pkg::*;

  logic [7:0]          term_reg;
  logic [7:0]          line_ien_reg;
  logic [7:0]          fault_ien_reg;
  logic [7:0]          edge_sel_reg;
  logic [7:0]          line_stat_reg;
  logic [7:0]          fault_stat_reg;
  logic [1:0]          live_reg;
  logic [SPREAD_W-1:0] spread_reg [2];
  logic [7:0]          line_set;
  logic [7:0]          fault_set;
  logic [7:0]          rdata_next;
  logic                wr_line;
  logic                wr_fault;
  logic [SPREAD_W-1:0] spread_in [2];
  logic                peak_mode [2];
  logic [7:0]          spread_ofs [2];

  assign spread_in[0]  = tx_pointer_spread_in;
  assign spread_in[1]  = rx_pointer_spread_in;
  assign peak_mode[0]  = tx_spread_peak_mode_in;
  assign peak_mode[1]  = rx_spread_peak_mode_in;
  assign spread_ofs[0] = TX_SPREAD_OFS;
  assign spread_ofs[1] = RX_SPREAD_OFS;

  // control registers, reserved bits held at zero
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      term_reg      <= TERM_RST;
      line_ien_reg  <= ZERO_BYTE;
      fault_ien_reg <= ZERO_BYTE;
      edge_sel_reg  <= ZERO_BYTE;
    end
    else if (wr_in)
    begin
      unique case (addr_in)
        TERM_OFS:      term_reg      <= wdata_in & 8'h1F;
        LINE_IEN_OFS:  line_ien_reg  <= wdata_in & LINE_MASK;
        FAULT_IEN_OFS: fault_ien_reg <= wdata_in & FAULT_MASK;
        EDGE_SEL_OFS:  edge_sel_reg  <= wdata_in & LINE_MASK;
        default:       term_reg      <= term_reg;
      endcase
    end
  end

  // tx field holds two stored bits; its top bit reads zero so only 000..011 occur
  assign tx_term_sel_out    = {1'b0, term_reg[TX_TERM_LSB+1:TX_TERM_LSB]};
  assign rx_term_sel_out    = term_reg[RX_TERM_LSB+2:RX_TERM_LSB];
  assign rx_term_bypass_out = term_reg[RX_TERM_LSB+2];

  // previous live values for change detection
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      live_reg <= 2'h0;
    else
      live_reg <= {driver_fault_live_in, signal_absent_live_in};
  end

  always_comb
  begin
    line_set = ZERO_BYTE;
    line_set[DRIVER_BIT] = edge_sel_reg[DRIVER_BIT]
      ? (driver_fault_live_in ^ live_reg[1])
      : (driver_fault_live_in & ~live_reg[1]);
    line_set[ABSENT_BIT] = edge_sel_reg[ABSENT_BIT]
      ? (signal_absent_live_in ^ live_reg[0])
      : (signal_absent_live_in & ~live_reg[0]);
    fault_set = ZERO_BYTE;
    fault_set[TEMPLATE_BIT] = template_overflow_in;
    fault_set[TX_FIFO_BIT]  = tx_fifo_fault_in;
    fault_set[RX_FIFO_BIT]  = rx_fifo_fault_in;
    fault_set[ZERO_BIT]     = zero_run_in;
    fault_set[BIPOLAR_BIT]  = bipolar_error_in;
    fault_set[WRAP_BIT]     = counter_wrap_in;
  end

  assign wr_line  = wr_in && (addr_in == LINE_STAT_OFS);
  assign wr_fault = wr_in && (addr_in == FAULT_STAT_OFS);

  // sticky flags; a same-cycle event beats the clear
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      line_stat_reg  <= ZERO_BYTE;
      fault_stat_reg <= ZERO_BYTE;
    end
    else
    begin
      line_stat_reg  <= ((line_stat_reg & ~(wr_line ? wdata_in : ZERO_BYTE))
                         | line_set) & LINE_MASK;
      fault_stat_reg <= ((fault_stat_reg & ~(wr_fault ? wdata_in : ZERO_BYTE))
                         | fault_set) & FAULT_MASK;
    end
  end

  // registered pin avoids glitches from the combined gating
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_n_out <= 1'b1;
    else
      irq_n_out <= ~(|(line_stat_reg & line_ien_reg)
                     | |(fault_stat_reg & fault_ien_reg));
  end

  // jitter depth capture, one per direction
  for (genvar i = 0; i < 2; i++)
  begin : g_spread
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
        spread_reg[i] <= SPREAD_W'(SPREAD_RST);
      else if (wr_in && addr_in == spread_ofs[i] && wdata_in != ZERO_BYTE)
        spread_reg[i] <= '0;
      else if (!peak_mode[i])
        spread_reg[i] <= spread_in[i];
      else if (rd_in && addr_in == spread_ofs[i])
        spread_reg[i] <= spread_in[i];
      else if (spread_in[i] > spread_reg[i])
        spread_reg[i] <= spread_in[i];
    end
  end

  always_comb
  begin
    rdata_next = ZERO_BYTE;
    unique case (addr_in)
      TERM_OFS:       rdata_next = term_reg;
      LINE_IEN_OFS:   rdata_next = line_ien_reg;
      FAULT_IEN_OFS:  rdata_next = fault_ien_reg;
      EDGE_SEL_OFS:   rdata_next = edge_sel_reg;
      LIVE_OFS:
      begin
        rdata_next[DRIVER_BIT] = driver_fault_live_in;
        rdata_next[ABSENT_BIT] = signal_absent_live_in;
      end
      GAIN_OFS:       rdata_next = {3'h0, rx_gain_code_in};
      TX_SPREAD_OFS:  rdata_next = 8'(spread_reg[0]);
      RX_SPREAD_OFS:  rdata_next = 8'(spread_reg[1]);
      LINE_STAT_OFS:  rdata_next = line_stat_reg;
      FAULT_STAT_OFS: rdata_next = fault_stat_reg;
      CNT_HI_OFS:     rdata_next = zero_count_in[15:8];
      CNT_LO_OFS:     rdata_next = zero_count_in[7:0];
      default:        rdata_next = ZERO_BYTE;
    endcase
  end

  // data stand only in the cycle after the read
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= ZERO_BYTE;
    else if (rd_in)
      rdata_out <= rdata_next;
    else
      rdata_out <= ZERO_BYTE;
  end
endmodule : line_status_interrupt_bank
`default_nettype wire

// ### bench/line_status_sva.sv
// assertion checker for the line status and interrupt bank
`timescale 1ns/1ns
`default_nettype none
module line_status_sva
  import line_status_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        driver_fault_live_in,
  input wire logic        signal_absent_live_in,
  input wire logic [4:0]  rx_gain_code_in,
  input wire logic [15:0] zero_count_in,
  input wire logic [2:0]  tx_term_sel_out,
  input wire logic [2:0]  rx_term_sel_out,
  input wire logic        rx_term_bypass_out,
  input wire logic        irq_n_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_rd(logic [7:0] a); rd_in && addr_in == a; endsequence
  sequence s_wr(logic [7:0] a); wr_in && addr_in == a; endsequence
  property p_gain; s_rd(GAIN_OFS) |=> rdata_out == {3'h0, $past(rx_gain_code_in)}; endproperty
  a_gain: assert property (p_gain) else $error("gain readback wrong");
  property p_live; s_rd(LIVE_OFS) |=> rdata_out ==
    {5'h0, $past(driver_fault_live_in), 1'b0, $past(signal_absent_live_in)}; endproperty
  a_live: assert property (p_live) else $error("live status wrong");
  property p_cnt; s_rd(CNT_HI_OFS) |=> {8'h0, rdata_out} == ($past(zero_count_in) >> 8); endproperty
  a_cnt: assert property (p_cnt) else $error("counter high byte wrong");
  property p_term; !tx_term_sel_out[2] && rx_term_bypass_out == rx_term_sel_out[2]; endproperty
  a_term: assert property (p_term) else $error("termination outputs wrong");
  property p_term_wr; s_wr(TERM_OFS) |=>
    {3'h0, tx_term_sel_out[1:0], rx_term_sel_out} == ($past(wdata_in) & 8'h1F); endproperty
  a_term_wr: assert property (p_term_wr) else $error("termination write lost");
  // flags are sticky, so only a write can release the pin
  property p_irq_rel; $rose(irq_n_out) |-> $past(wr_in, 2); endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("pin released without write");
  property p_fault_rsv; s_rd(FAULT_STAT_OFS) |=> (rdata_out & ~FAULT_MASK) == 8'h00; endproperty
  a_fault_rsv: assert property (p_fault_rsv) else $error("fault reserved bits set");
  property p_line_rsv; s_rd(LINE_STAT_OFS) |=> (rdata_out & ~LINE_MASK) == 8'h00; endproperty
  a_line_rsv: assert property (p_line_rsv) else $error("line reserved bits set");
endmodule : line_status_sva
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the line status and interrupt bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import line_status_pkg::*;
  logic clk_in, rst_n_in, wr_in, rd_in, driver_fault_live_in, signal_absent_live_in;
  logic tx_spread_peak_mode_in, rx_spread_peak_mode_in, rx_term_bypass_out, irq_n_out;
  logic [7:0] addr_in, wdata_in, rdata_out, d, a;
  logic [4:0] rx_gain_code_in;
  logic [6:0] tx_pointer_spread_in, rx_pointer_spread_in;
  logic [15:0] zero_count_in;
  logic [2:0] tx_term_sel_out, rx_term_sel_out;
  logic [5:0] ev;
  int error_cnt, cmp_count, k, p;
  line_status_interrupt_bank DUT (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .driver_fault_live_in, .signal_absent_live_in, .rx_gain_code_in,
    .tx_pointer_spread_in, .rx_pointer_spread_in, .tx_spread_peak_mode_in,
    .rx_spread_peak_mode_in, .template_overflow_in(ev[5]), .tx_fifo_fault_in(ev[4]),
    .rx_fifo_fault_in(ev[3]), .zero_run_in(ev[2]), .bipolar_error_in(ev[1]),
    .counter_wrap_in(ev[0]), .zero_count_in, .tx_term_sel_out, .rx_term_sel_out,
    .rx_term_bypass_out, .irq_n_out);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] ad, logic [7:0] v);
    @(posedge clk_in);
    addr_in <= ad;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the strobe, so look mid-cycle
  task automatic rd(logic [7:0] ad, logic [7:0] e, string n);
    @(posedge clk_in);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(n, e, rdata_out);
  endtask : rd
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : tick
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    {rst_n_in, wr_in, rd_in, driver_fault_live_in, signal_absent_live_in} = '0;
    {tx_spread_peak_mode_in, rx_spread_peak_mode_in, addr_in, wdata_in, ev} = '0;
    {rx_gain_code_in, tx_pointer_spread_in, rx_pointer_spread_in, zero_count_in} = '0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(TERM_OFS, TERM_RST, "term reset");
    chk("term out", 8'h87, {rx_term_bypass_out, tx_term_sel_out, 1'b0, rx_term_sel_out});
    for (k = 'h33; k < 'h3C; k++)
      rd(8'(k), ZERO_BYTE, "reset value");
    for (k = 0; k < 8; k++)
    begin
      d = {3'h0, 2'(k), 3'(k)};
      wr(TERM_OFS, d);
      rd(TERM_OFS, d, "term");
      chk("term out", {k[2], 1'b0, 2'(k), 1'b0, 3'(k)},
        {rx_term_bypass_out, tx_term_sel_out, 1'b0, rx_term_sel_out});
    end
    for (k = 0; k < 6; k++)
    begin
      p = (k > 2) ? k + 1 : k;
      d = 8'(1 << p);
      @(posedge clk_in);
      ev <= 6'(1 << k);
      @(posedge clk_in);
      ev <= 6'h00;
      tick(3);
      chk("irq masked", 8'h01, {7'h0, irq_n_out});
      wr(FAULT_STAT_OFS, ~d);
      rd(FAULT_STAT_OFS, d, "fault flag");
      wr(FAULT_IEN_OFS, d);
      tick(3);
      chk("irq on", 8'h00, {7'h0, irq_n_out});
      wr(FAULT_STAT_OFS, d);
      tick(3);
      chk("irq cleared", 8'h01, {7'h0, irq_n_out});
    end
    for (k = 0; k < 2; k++)
    begin
      wr(EDGE_SEL_OFS, k[0] ? LINE_MASK : ZERO_BYTE);
      wr(LINE_IEN_OFS, ZERO_BYTE);
      {driver_fault_live_in, signal_absent_live_in} <= 2'b11;
      tick(3);
      chk("line irq masked", 8'h01, {7'h0, irq_n_out});
      wr(LINE_IEN_OFS, LINE_MASK);
      rd(LIVE_OFS, LINE_MASK, "live");
      rd(LINE_STAT_OFS, LINE_MASK, "rise flag");
      chk("line irq", 8'h00, {7'h0, irq_n_out});
      wr(LINE_STAT_OFS, LINE_MASK);
      {driver_fault_live_in, signal_absent_live_in} <= 2'b00;
      tick(3);
      rd(LINE_STAT_OFS, k[0] ? LINE_MASK : ZERO_BYTE, "fall flag");
      wr(LINE_STAT_OFS, LINE_MASK);
    end
    for (k = 1; k < 32; k += 5)
    begin
      rx_gain_code_in <= 5'(k);
      rd(GAIN_OFS, 8'(k), "gain");
    end
    for (k = 0; k < 2; k++)
    begin
      a = k[0] ? RX_SPREAD_OFS : TX_SPREAD_OFS;
      {tx_spread_peak_mode_in, rx_spread_peak_mode_in} <= 2'b00;
      {tx_pointer_spread_in, rx_pointer_spread_in} <= {2{7'h25}};
      rd(a, 8'h25, "spread now");
      {tx_spread_peak_mode_in, rx_spread_peak_mode_in} <= 2'b11;
      tick(1);
      {tx_pointer_spread_in, rx_pointer_spread_in} <= {2{7'h28}};
      tick(2);
      {tx_pointer_spread_in, rx_pointer_spread_in} <= {2{7'h0A}};
      tick(2);
      rd(a, 8'h28, "spread peak");
      {tx_pointer_spread_in, rx_pointer_spread_in} <= {2{7'h05}};
      rd(a, 8'h0A, "peak restart");
      {tx_pointer_spread_in, rx_pointer_spread_in} <= '0;
      wr(a, 8'h01);
      rd(a, 8'h00, "spread clear");
    end
    zero_count_in <= 16'hA55A;
    rd(CNT_HI_OFS, 8'hA5, "count high");
    rd(CNT_LO_OFS, 8'h5A, "count low");
    rd(8'h00, ZERO_BYTE, "unmapped");
    wrap_up();
  end
endmodule : tb_top
bind line_status_interrupt_bank line_status_sva u_sva (.clk_in, .rst_n_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .driver_fault_live_in, .signal_absent_live_in,
  .rx_gain_code_in, .zero_count_in, .tx_term_sel_out, .rx_term_sel_out,
  .rx_term_bypass_out, .irq_n_out);
`default_nettype wire
